/* File: inc/cis_pkg.sv */
// package: shared constants for the cpu interrupt signaling block
package cis_pkg;
    // register byte offsets on the apb slave
    localparam logic [11:0] OFS_CTRL = 12'h000;    // mode and enable
    localparam logic [11:0] OFS_ACK = 12'h004;     // acknowledge read
    localparam logic [11:0] OFS_EOI = 12'h008;     // end of interrupt write
    localparam logic [11:0] OFS_ACTIVE = 12'h00C;  // active status
    localparam logic [11:0] OFS_PEND = 12'h010;    // pending status
    localparam logic [11:0] OFS_SEC = 12'h014;     // secure group per source
    localparam logic [11:0] OFS_PRIO_LO = 12'h018; // priority, sources 0..7
    localparam logic [11:0] OFS_PRIO_HI = 12'h01C; // priority, sources 8..15
    localparam logic [11:0] OFS_IRQ_ST = 12'h020;  // sticky event status
    localparam logic [11:0] OFS_IRQ_MSK = 12'h024; // event mask
    // control register fields
    localparam int CTRL_EN_BIT = 0;      // signalling enable
    localparam int CTRL_SPLIT_BIT = 1;   // secure on fast line
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;
    // spurious id when nothing is pending
    localparam logic [9:0] SPURIOUS_ID = 10'h3FF;
    // prioritisation latency in core clocks, allowed range
    localparam int LAT_MIN = 1;
    localparam int LAT_MAX = 10;
    localparam int LAT_DEFAULT = 2;
    // sticky event bit positions
    localparam int EV_SIG = 0;   // request newly signalled
    localparam int EV_ACK = 1;   // acknowledge taken
    localparam int EV_EOI = 2;   // completion taken
endpackage : cis_pkg

/* File: inc/cis_sel_if.sv */
// interface: carries the highest priority pick between selector and core
`timescale 1ns/1ps
`default_nettype none
interface cis_sel_if #(parameter int NSRC = 16);
    logic found;            // some pending source is not yet active
    logic [3:0] idx;        // index of best source
    logic secure;           // security group of best source
    logic [NSRC-1:0] cand;  // candidate vector
    logic [NSRC*4-1:0] prio;// priorities, lower value wins
    modport core (output cand, output prio, input found, input idx, input secure);
    modport sel (input cand, input prio, output found, output idx, output secure);
endinterface : cis_sel_if
`default_nettype wire

/* File: hdl/cis_prio_sel.sv */
// module: combinational highest priority selector
`timescale 1ns/1ps
`default_nettype none
module cis_prio_sel #(
    parameter int NSRC = 16
) (
    // pick port
    cis_sel_if.sel sel,
    // security group of each source
    input wire logic [NSRC-1:0] sec_in
);
    // linear scan, lowest value wins and ties go to the lowest index
    always_comb begin
        logic [3:0] best_p;
        best_p = 4'hF;
        sel.found = 1'b0;
        sel.idx = 4'h0;
        sel.secure = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (sel.cand[i] && (!sel.found || sel.prio[i*4 +: 4] < best_p)) begin
                sel.found = 1'b1;
                best_p = sel.prio[i*4 +: 4];
                sel.idx = 4'(i);
                sel.secure = sec_in[i];
            end
        end
    end
endmodule : cis_prio_sel
`default_nettype wire

/* File: hdl/cis_cpu_sig.sv */
// module: processor interface request signaling with apb register access
// Contract
// R01 - single state: secure interrupts use normal line
// R02 - normal line low until acknowledge read
// R03 - detect input, then mark pending, then signal
// R04 - request asserts fixed latency after pending
// R05 - new pending restarts full latency count
// R06 - higher priority pre-empts next clock cycle
// R07 - pre-empting id loaded into acked id
// R08 - acknowledge deasserts line, marks interrupt active
// R09 - end of interrupt write clears active
// R10 - completion passes next pending, reasserts after latency
// R11 - control bit picks single or split mode
// R12 - split mode line chosen by security state
// R13 - fast held until ack; normal until ack/fast
// R14 - secure pre-empt: fast on, normal off together
// R15 - fast output only with security support
// R16 - request outputs registered, reset high
// R17 - no glitch when pending interrupt replaced
`timescale 1ns/1ps
`default_nettype none
module cis_cpu_sig #(
    parameter int NSRC = 16,                      // interrupt sources
    parameter int LATENCY = cis_pkg::LAT_DEFAULT, // prioritisation clocks, 1..10
    parameter bit SEC_SUPPORT = 1'b1              // fast line built in
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // interrupt inputs from peripherals, active high level
    input wire logic [NSRC-1:0] irq_src_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // processor request lines, active low
    output logic irq_n_out,
    output logic fiq_n_out,
    // event interrupt
    output logic evt_irq_out
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers; first stage read only by the second
    logic [NSRC-1:0] sync1_reg, sync1_next;
    logic [NSRC-1:0] sync2_reg, sync2_next;
    always_comb begin
        sync1_next = irq_src_in;
        sync2_next = sync1_reg;
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic wr_acc, rd_acc;
    assign wr_acc = psel_in && penable_in && pwrite_in && pready_out;
    assign rd_acc = psel_in && penable_in && !pwrite_in && pready_out;
    logic ack_rd, eoi_wr;
    assign ack_rd = rd_acc && paddr_in == cis_pkg::OFS_ACK;
    assign eoi_wr = wr_acc && paddr_in == cis_pkg::OFS_EOI;

    ////////////////////////////////////////////////////////////////////////
    // state registers
    logic [31:0] ctrl_reg, ctrl_next;       // enable and split bits
    logic [NSRC-1:0] pend_reg, pend_next;   // pending per source
    logic [NSRC-1:0] act_reg, act_next;     // active status
    logic [NSRC-1:0] sec_reg, sec_next;     // secure group
    logic [NSRC*4-1:0] prio_reg, prio_next; // priority nibbles
    logic [9:0] acked_interrupt_id_reg, acked_interrupt_id_next;
    logic cur_valid_reg, cur_valid_next;    // acked id holds a real pick, not the spurious id
    logic [3:0] lat_cnt_reg, lat_cnt_next;  // prioritisation countdown
    logic irq_n_reg, irq_n_next;
    logic fiq_n_reg, fiq_n_next;
    logic [2:0] ev_st_reg, ev_st_next;      // sticky events
    logic [2:0] ev_msk_reg, ev_msk_next;    // event mask
    logic evt_irq_reg, evt_irq_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;

    // selector over pending sources not yet active
    cis_sel_if #(.NSRC(NSRC)) sel_bus ();
    assign sel_bus.cand = pend_reg & ~act_reg;
    assign sel_bus.prio = prio_reg;
    cis_prio_sel #(.NSRC(NSRC)) u_sel (
        .sel(sel_bus),
        .sec_in(sec_reg)
    );

    // level inputs: a source still high after completion pends again,
    // so the peripheral must drop its line before the core completes
    logic [NSRC-1:0] new_pend;
    assign new_pend = sync2_reg & ~pend_reg & ~act_reg; // R03

    // effective split: only when fast line exists
    logic split_mode;
    assign split_mode = SEC_SUPPORT && ctrl_reg[cis_pkg::CTRL_SPLIT_BIT]; // R11 R15

    ////////////////////////////////////////////////////////////////////////
    // signaling next state
    always_comb begin
        pend_next = pend_reg | new_pend; // R03
        act_next = act_reg;
        acked_interrupt_id_next = acked_interrupt_id_reg;
        cur_valid_next = cur_valid_reg;
        lat_cnt_next = lat_cnt_reg;
        irq_n_next = irq_n_reg;
        fiq_n_next = fiq_n_reg;
        // any new pending restarts the full window, which reruns the pick
        if (|new_pend) begin
            lat_cnt_next = 4'(LATENCY); // R05
        end else if (lat_cnt_reg != 4'h0) begin
            lat_cnt_next = lat_cnt_reg - 4'h1; // R04
        end
        // acked id follows the current best pick one cycle behind pending
        if (sel_bus.found) begin
            acked_interrupt_id_next = {6'h00, sel_bus.idx}; // R06 R07
            cur_valid_next = 1'b1;
        end else begin
            acked_interrupt_id_next = cis_pkg::SPURIOUS_ID;
            cur_valid_next = 1'b0;
        end
        // latency expired: drive the line for the current pick
        // live pick, not the registered one: with a latency of one the
        // registered pick would still be empty at the expiry cycle
        if (lat_cnt_reg == 4'h1 && !(|new_pend) && sel_bus.found
            && ctrl_reg[cis_pkg::CTRL_EN_BIT]) begin
            if (split_mode && sel_bus.secure) begin
                fiq_n_next = 1'b0; // R12 R13
                irq_n_next = 1'b1; // R14
            end else begin
                irq_n_next = 1'b0; // R01 R02 R12 R17
            end
        end
        // acknowledge read releases lines and activates the pick
        if (ack_rd) begin
            irq_n_next = 1'b1; // R02 R08 R13
            fiq_n_next = 1'b1; // R13
            if (cur_valid_reg) begin
                act_next[acked_interrupt_id_reg[3:0]] = 1'b1; // R08
                pend_next[acked_interrupt_id_reg[3:0]] = 1'b0;
            end
        end
        // completion clears active and restarts latency for the next pick
        if (eoi_wr && pwdata_in[9:4] == 6'h00 && act_reg[pwdata_in[3:0]]) begin
            act_next[pwdata_in[3:0]] = 1'b0; // R09
            lat_cnt_next = 4'(LATENCY); // R10
        end
        if (!SEC_SUPPORT) fiq_n_next = 1'b1; // R15
    end

    ////////////////////////////////////////////////////////////////////////
    // apb register next state
    always_comb begin
        ctrl_next = ctrl_reg;
        sec_next = sec_reg;
        prio_next = prio_reg;
        ev_msk_next = ev_msk_reg;
        ev_st_next = ev_st_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        // one wait state: ready rises in the second access cycle
        pready_next = psel_in && penable_in && !pready_reg;
        if (wr_acc) begin
            unique case (paddr_in)
                cis_pkg::OFS_CTRL: ctrl_next = {30'h0000_0000, pwdata_in[1:0]}; // R11
                cis_pkg::OFS_SEC: sec_next = pwdata_in[NSRC-1:0];
                cis_pkg::OFS_PRIO_LO: prio_next[31:0] = pwdata_in;
                cis_pkg::OFS_PRIO_HI: prio_next[NSRC*4-1:32] = pwdata_in[NSRC*4-33:0];
                cis_pkg::OFS_IRQ_MSK: ev_msk_next = pwdata_in[2:0];
                cis_pkg::OFS_EOI: ;
                default: pslverr_next = 1'b0;
            endcase
        end
        if (psel_in && penable_in && !pwrite_in && !pready_reg) begin
            unique case (paddr_in)
                cis_pkg::OFS_CTRL: prdata_next = ctrl_reg;
                cis_pkg::OFS_ACK: prdata_next = {22'h00_0000, acked_interrupt_id_reg};
                cis_pkg::OFS_ACTIVE: prdata_next = 32'(act_reg);
                cis_pkg::OFS_PEND: prdata_next = 32'(pend_reg);
                cis_pkg::OFS_SEC: prdata_next = 32'(sec_reg);
                cis_pkg::OFS_PRIO_LO: prdata_next = prio_reg[31:0];
                cis_pkg::OFS_PRIO_HI: prdata_next = prio_reg[NSRC*4-1:32];
                cis_pkg::OFS_IRQ_ST: prdata_next = {29'h0000_0000, ev_st_reg};
                cis_pkg::OFS_IRQ_MSK: prdata_next = {29'h0000_0000, ev_msk_reg};
                default: prdata_next = cis_pkg::ZERO_RST;
            endcase
        end
        // sticky events: read clears, a new event wins over the clear
        if (rd_acc && paddr_in == cis_pkg::OFS_IRQ_ST) ev_st_next = 3'h0;
        if ((irq_n_reg && !irq_n_next) || (fiq_n_reg && !fiq_n_next))
            ev_st_next[cis_pkg::EV_SIG] = 1'b1;
        if (ack_rd) ev_st_next[cis_pkg::EV_ACK] = 1'b1;
        if (eoi_wr) ev_st_next[cis_pkg::EV_EOI] = 1'b1;
        evt_irq_next = |(ev_st_next & ev_msk_next);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= cis_pkg::CTRL_RST;
            pend_reg <= '0;
            act_reg <= '0;
            sec_reg <= '0;
            prio_reg <= '0;
            acked_interrupt_id_reg <= cis_pkg::SPURIOUS_ID;
            cur_valid_reg <= 1'b0;
            lat_cnt_reg <= 4'h0;
            irq_n_reg <= 1'b1; // R16
            fiq_n_reg <= 1'b1; // R16
            ev_st_reg <= 3'h0;
            ev_msk_reg <= 3'h0;
            evt_irq_reg <= 1'b0;
            prdata_reg <= cis_pkg::ZERO_RST;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            pend_reg <= pend_next;
            act_reg <= act_next;
            sec_reg <= sec_next;
            prio_reg <= prio_next;
            acked_interrupt_id_reg <= acked_interrupt_id_next;
            cur_valid_reg <= cur_valid_next;
            lat_cnt_reg <= lat_cnt_next;
            irq_n_reg <= irq_n_next;
            fiq_n_reg <= fiq_n_next;
            ev_st_reg <= ev_st_next;
            ev_msk_reg <= ev_msk_next;
            evt_irq_reg <= evt_irq_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // outputs straight from flip-flops
    assign irq_n_out = irq_n_reg;
    assign fiq_n_out = fiq_n_reg;
    assign evt_irq_out = evt_irq_reg;
    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
endmodule : cis_cpu_sig
`default_nettype wire

/* File: sim/cis_cpu_sig_sva.sv */
// checker: request line and apb timing properties of the signaling block
`timescale 1ns/1ps
`default_nettype none
module cis_cpu_sig_sva #(
    parameter int NSRC = 16,
    parameter int LATENCY = 2,
    parameter bit SEC_SUPPORT = 1'b1
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // watched inputs
    input wire logic [NSRC-1:0] irq_src_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    // watched outputs
    input wire logic pready_out,
    input wire logic irq_n_out,
    input wire logic fiq_n_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////
    logic ack_done; // acknowledge read completes at this edge
    logic [NSRC-1:0] src_reg, src_next;
    logic [3:0] quiet_reg, quiet_next; // cycles since a source last rose
    assign ack_done = psel_in && penable_in && pready_out && !pwrite_in
        && (paddr_in == cis_pkg::OFS_ACK);
    // saturating so a long quiet spell cannot wrap into a false short one
    always_comb begin
        src_next = irq_src_in;
        quiet_next = (quiet_reg == 4'hF) ? quiet_reg : quiet_reg + 4'h1;
        if (|(irq_src_in & ~src_reg)) begin
            quiet_next = 4'h0;
        end
    end
    // register the helper state
    always_ff @(posedge ref_clk_in) begin
        src_reg <= sys_rst_in ? '0 : src_next;
        quiet_reg <= sys_rst_in ? 4'h0 : quiet_next;
    end
    ////////////////////////////////////////////////////////////////
    lines_reset_a: assert property (disable iff (1'b0) sys_rst_in |=> irq_n_out && fiq_n_out)
        else $error("request line low after reset");
    one_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("apb answer not after one wait");
    fast_absent_a: assert property (!SEC_SUPPORT |-> fiq_n_out)
        else $error("fast line driven without support");
    irq_hold_a: assert property (!irq_n_out && !ack_done |=> !irq_n_out || $fell(fiq_n_out))
        else $error("normal line released early");
    fiq_hold_a: assert property (!fiq_n_out && !ack_done |=> !fiq_n_out)
        else $error("fast line released early");
    ack_release_a: assert property (ack_done |=> irq_n_out && fiq_n_out)
        else $error("line still low after acknowledge");
    fiq_swap_a: assert property ($fell(fiq_n_out) |-> irq_n_out)
        else $error("normal line not released with fast");
    latency_floor_a: assert property ($fell(irq_n_out) || $fell(fiq_n_out)
        |-> quiet_reg >= LATENCY + 1)
        else $error("line fell before latency");
    cover property ($fell(irq_n_out));
    cover property ($fell(fiq_n_out));
    cover property (ack_done && !fiq_n_out);
endmodule // cis_cpu_sig_sva
bind cis_cpu_sig cis_cpu_sig_sva #(.NSRC(NSRC), .LATENCY(LATENCY), .SEC_SUPPORT(SEC_SUPPORT))
    sva_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .irq_src_in(irq_src_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pready_out(pready_out), .irq_n_out(irq_n_out), .fiq_n_out(fiq_n_out));
`default_nettype wire

/* File: sim/cis_cpu_model.sv */
// model: processor core that decides when to acknowledge a request
`timescale 1ns/1ps
`default_nettype none
module cis_cpu_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // request lines, active low
    input wire logic irq_n_in,
    input wire logic fiq_n_in,
    // slow answer when high
    input wire logic slow_in,
    // core is ready to read the acknowledge register
    output logic ack_want_out
);
    logic [3:0] wait_reg; // cycles a line has stayed low
    // core only acks while a line is low, after its own delay
    always_ff @(posedge clk_in) begin
        if (rst_in || (irq_n_in && fiq_n_in)) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != 4'hF) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
    assign ack_want_out = wait_reg >= (slow_in ? 4'h8 : 4'h1);
endmodule // cis_cpu_model
`default_nettype wire

/* File: sim/tb.sv */
// testbench: drives apb and sources, checks request lines and read data
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int LAT = 3; // short latency keeps runs brief
    logic clk, rst, psel, pen, pwr, prdy, perr, irq_n, fiq_n, evt, slow, ack_want;
    logic [11:0] paddr;
    logic [31:0] pwd, prd;
    logic [15:0] src;
    logic [31:0] q[$]; // expected read data, oldest first
    int n_mismatch, n_checks, cyc, n, seed;
    cis_cpu_sig #(.NSRC(16), .LATENCY(LAT), .SEC_SUPPORT(1'b1)) cis_cpu_sig_inst (
        .ref_clk_in(clk), .sys_rst_in(rst), .irq_src_in(src), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .irq_n_out(irq_n),
        .fiq_n_out(fiq_n), .evt_irq_out(evt));
    cis_cpu_model cis_cpu_model_inst (.clk_in(clk), .rst_in(rst), .irq_n_in(irq_n),
        .fiq_n_in(fiq_n), .slow_in(slow), .ack_want_out(ack_want));
    ////////////////////////////////////////////////////////////////
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
            n_mismatch++;
        end
    endtask
    task automatic chk_pin(input logic [31:0] got, input logic [31:0] want);
        chk_rd(got, want);
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (prdy !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        q.push_back(want);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // count edges until the chosen line is sampled low
    task automatic wait_fall(input logic fast_l, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while ((fast_l ? fiq_n : irq_n) !== 1'b0);
    endtask
    // core model decides when to read the acknowledge register
    task automatic ack(input logic [31:0] id);
        int k;
        k = 0;
        while (ack_want !== 1'b1) begin
            @(posedge clk);
            k++;
        end
        rd(cis_pkg::OFS_ACK, id);
    endtask
    // source drops, then the core signals completion
    task automatic service(input logic [31:0] id);
        src[id[3:0]] <= 1'b0;
        wr(cis_pkg::OFS_EOI, id);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // watcher: each completed read is compared with the oldest note
    always @(posedge clk) begin
        if (psel && pen && prdy === 1'b1 && !pwr && q.size() > 0) begin
            chk_rd(prd, q.pop_front());
            chk_pin(perr, 1'b0);
        end
    end
    // hang guard, far above the run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        seed = 50;
        cyc = 0;
        n_mismatch = 0;
        n_checks = 0;
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h000;
        pwd = 32'h0000_0000;
        src = 16'h0000;
        slow = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_pin(irq_n, 1'b1);
        chk_pin(fiq_n, 1'b1);
        rd(cis_pkg::OFS_CTRL, cis_pkg::CTRL_RST);
        wr(12'h040, $random(seed));
        rd(12'h040, cis_pkg::ZERO_RST);
        wr(cis_pkg::OFS_SEC, 32'h0000_0004);
        wr(cis_pkg::OFS_PRIO_LO, 32'h0040_0100);
        $display("reset test done");
        // single state: secure source 2 on the normal line
        src[2] <= 1'b1;
        wait_fall(1'b0, n);
        chk_pin(n, LAT + 4);
        chk_pin(fiq_n, 1'b1);
        ack(32'h0000_0002);
        chk_pin(irq_n, 1'b1);
        rd(cis_pkg::OFS_ACTIVE, 32'h0000_0004);
        service(32'h0000_0002);
        rd(cis_pkg::OFS_ACTIVE, cis_pkg::ZERO_RST);
        $display("single test done");
        // higher priority arrives inside the latency window
        slow <= 1'($random(seed));
        src[5] <= 1'b1;
        repeat (2) @(posedge clk);
        src[2] <= 1'b1;
        wait_fall(1'b0, n);
        chk_pin(n, LAT + 4);
        ack(32'h0000_0002);
        service(32'h0000_0002);
        wait_fall(1'b0, n);
        chk_pin(irq_n, 1'b0);
        ack(32'h0000_0005);
        service(32'h0000_0005);
        $display("restart test done");
        // split mode: secure source pre-empts a signalled one
        slow <= 1'($random(seed));
        wr(cis_pkg::OFS_CTRL, 32'h0000_0003);
        src[5] <= 1'b1;
        wait_fall(1'b0, n);
        chk_pin(fiq_n, 1'b1);
        src[2] <= 1'b1;
        wait_fall(1'b1, n);
        chk_pin(n, LAT + 4);
        chk_pin(irq_n, 1'b1);
        ack(32'h0000_0002);
        chk_pin(fiq_n, 1'b1);
        service(32'h0000_0002);
        wait_fall(1'b0, n);
        chk_pin(irq_n, 1'b0);
        ack(32'h0000_0005);
        service(32'h0000_0005);
        $display("split test done");
        // event status: sticky, read clears, mask hides it
        rd(cis_pkg::OFS_IRQ_ST, 32'h0000_0007);
        rd(cis_pkg::OFS_IRQ_ST, cis_pkg::ZERO_RST);
        chk_pin(evt, 1'b0);
        wr(cis_pkg::OFS_IRQ_MSK, 32'h0000_0001);
        src[3] <= 1'b1;
        wait_fall(1'b0, n);
        repeat (2) @(posedge clk);
        chk_pin(evt, 1'b1);
        wr(cis_pkg::OFS_IRQ_MSK, cis_pkg::ZERO_RST);
        chk_pin(evt, 1'b0);
        rd(cis_pkg::OFS_IRQ_ST, 32'h0000_0001);
        chk_pin(evt, 1'b0);
        $display("event test done");
        final_report();
    end
endmodule // tb
`default_nettype wire
